// file: core/rss_core.sv
// APB-controlled execution unit for rotate, subtract, skip and table instructions
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module rss_core
  import rss_pkg::*;
#(
  parameter int MEM_AW = RSS_MEM_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] tbl_addr,
  input wire logic [15:0] tbl_word,
  output logic busy,
  output logic skip_pulse
);

  localparam int MEM_N = 1 << MEM_AW;

  // ==================================================
  // State
  rss_state_t state_r;
  rss_state_t state_nxt;
  logic [7:0] acc_r;
  rss_flags_t flags_r;
  logic [7:0] tptr_r;
  logic [7:0] thi_r;
  logic [7:0] page_r;
  logic [15:0] tbl_addr_r;
  logic skip_seen_r;
  rss_op_t op_r;
  logic [2:0] bit_r;
  logic [MEM_AW-1:0] adr_r;
  logic [7:0] imm_r;
  logic [7:0] mem_r [MEM_N];
  rss_alu_out_t alu;

  // ==================================================
  // APB decode
  wire logic acc_phase = psel & penable;
  wire logic in_mem = (paddr >= RSS_OFF_MEM) && (paddr < RSS_OFF_MEM + 12'(4 * MEM_N)) && (paddr[1:0] == 2'b00);
  wire logic [11:0] mem_off = paddr - RSS_OFF_MEM;
  wire logic [MEM_AW-1:0] bus_idx = mem_off[MEM_AW+1:2];
  wire logic hit_instr = (paddr == RSS_OFF_INSTR);
  wire logic hit_acc = (paddr == RSS_OFF_ACC);
  wire logic hit_status = (paddr == RSS_OFF_STATUS);
  wire logic hit_tptr = (paddr == RSS_OFF_TPTR);
  wire logic hit_thi = (paddr == RSS_OFF_THI);
  wire logic hit_page = (paddr == RSS_OFF_PAGE);
  wire logic mapped = hit_instr | hit_acc | hit_status | hit_tptr | hit_thi | hit_page | in_mem;
  wire logic idle = (state_r == st_idle);
  // Writes while an instruction runs are refused so the datapath owns the state
  wire logic wr_ok = acc_phase & pwrite & mapped & idle & ~hit_thi;
  wire logic wr_err = acc_phase & ((pwrite & ~wr_ok) | (~pwrite & ~mapped));
  wire logic launch = wr_ok & hit_instr;
  wire logic [31:0] status_word = {22'h000000, skip_seen_r, ~idle, 4'h0, flags_r.ovf, flags_r.z, flags_r.aux, flags_r.c};

  assign pready = 1'b1;
  assign pslverr = wr_err;
  assign busy = ~idle;
  assign skip_pulse = (state_r == st_dummy);
  assign tbl_addr = tbl_addr_r;

  // Read data mux
  always_comb begin
    prdata = 32'h00000000;
    if (acc_phase & ~pwrite) begin
      if (hit_instr)
        prdata = {8'h00, imm_r, 4'h0, 4'(adr_r), 3'(bit_r), 5'(op_r)};
      else if (hit_acc)
        prdata = {24'h000000, acc_r};
      else if (hit_status)
        prdata = status_word;
      else if (hit_tptr)
        prdata = {24'h000000, tptr_r};
      else if (hit_thi)
        prdata = {24'h000000, thi_r};
      else if (hit_page)
        prdata = {24'h000000, page_r};
      else if (in_mem)
        prdata = {24'h000000, mem_r[bus_idx]};
    end
  end

  // ==================================================
  // Datapath
  rss_alu u_alu (
    .op(op_r),
    .acc(acc_r),
    .mem(mem_r[adr_r]),
    .imm(imm_r),
    .bsel(bit_r),
    .fl_in(flags_r),
    .out(alu)
  );

  // ==================================================
  // Sequencer: execute, then dummy cycle for a taken skip or table cycle for a table fetch
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_idle: if (launch) state_nxt = st_exec;
      st_exec: begin
        if (alu.tbl)
          state_nxt = st_table;
        else if (alu.skip)
          state_nxt = st_dummy; // see [RQ18]
        else
          state_nxt = st_idle;
      end
      st_table: state_nxt = st_idle;
      st_dummy: state_nxt = st_idle; // see [RQ18]
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= st_idle;
    else state_r <= state_nxt;
  end

  // Instruction latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= rotate_right;
      bit_r <= 3'h0;
      adr_r <= '0;
      imm_r <= 8'h00;
    end else if (launch) begin
      op_r <= rss_op_t'(pwdata[RSS_INSTR_OP_LSB +: 5]);
      bit_r <= pwdata[RSS_INSTR_BIT_LSB +: 3];
      adr_r <= pwdata[RSS_INSTR_ADR_LSB +: MEM_AW];
      imm_r <= pwdata[RSS_INSTR_IMM_LSB +: 8];
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acc_r <= RSS_ACC_RST;
    else if (wr_ok & hit_acc) acc_r <= pwdata[7:0];
    else if ((state_r == st_exec) & alu.wr_acc) acc_r <= alu.res; // see [RQ2] see [RQ17]
  end

  // Flags: datapath updates only listed flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flags_r <= '0;
    else if (wr_ok & hit_status) flags_r <= {pwdata[RSS_ST_OVF], pwdata[RSS_ST_Z], pwdata[RSS_ST_AUX], pwdata[RSS_ST_C]};
    else if (state_r == st_exec) flags_r <= alu.fl; // see [RQ23]
  end

  // Sticky skip indicator; a new skip wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) skip_seen_r <= 1'b0;
    else if (state_r == st_dummy) skip_seen_r <= 1'b1;
    else if (wr_ok & hit_status & pwdata[RSS_ST_SKIP]) skip_seen_r <= 1'b0;
  end

  // Table pointer, page and fetch address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tptr_r <= RSS_TPTR_RST;
      page_r <= RSS_PAGE_RST;
      tbl_addr_r <= {RSS_PAGE_RST, RSS_TPTR_RST};
    end else begin
      if (wr_ok & hit_tptr) tptr_r <= pwdata[7:0];
      if (wr_ok & hit_page) page_r <= pwdata[7:0];
      if (state_r == st_exec && alu.tbl)
        tbl_addr_r <= {(op_r == table_read_last_page) ? RSS_LAST_PAGE : page_r, tptr_r}; // see [RQ21]
    end
  end

  // High-byte latch loads one cycle after the fetch address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) thi_r <= RSS_THI_RST;
    else if (state_r == st_table) thi_r <= tbl_word[15:8]; // see [RQ21]
  end

  // ==================================================
  // Data memory: bus writes when idle, datapath writes otherwise
  always_ff @(posedge pclk) begin
    if (wr_ok & in_mem)
      mem_r[bus_idx] <= pwdata[7:0];
    else if (state_r == st_table)
      mem_r[adr_r] <= tbl_word[7:0]; // see [RQ21]
    else if ((state_r == st_exec) & alu.wr_mem)
      mem_r[adr_r] <= alu.res; // see [RQ1] see [RQ10] see [RQ12]
  end

endmodule : rss_core

// file: core/rss_pkg.sv
// Constants, types and register map of the rotate/subtract/skip datapath
// Notes on behaviour
// [RQ1] Rotate left via carry: carry in, bit7 out
// [RQ2] Accumulator form: memory kept, carry from bit7
// [RQ3] Rotate right wraps bit0 to bit7, flags kept
// [RQ4] Rotate right to accumulator, memory kept
// [RQ5] Rotate right via carry: carry in, bit0 out
// [RQ6] Accumulator form: memory kept, carry from bit0
// [RQ7] Subtract with borrow: acc minus mem minus not-C
// [RQ8] Carry cleared on negative, set otherwise
// [RQ9] Subtracts update overflow, zero, aux-carry and carry
// [RQ10] Subtract into memory stores difference in memory
// [RQ11] Immediate subtract: acc minus immediate into acc
// [RQ12] Decrement memory, skip on zero, flags kept
// [RQ13] Decrement to accumulator, memory kept, skip on zero
// [RQ14] Increment to memory or accumulator, skip on zero
// [RQ15] Skip when selected bit is one
// [RQ16] Skip when selected bit is zero
// [RQ17] Skip on zero byte; move form loads accumulator
// [RQ18] Taken skip costs a second, dummy cycle
// [RQ19] Set byte to all ones or one bit
// [RQ20] Swap nibbles, accumulator form keeps memory
// [RQ21] Table read: low byte to memory, high latch
// [RQ22] Exclusive-or to acc or memory, zero flag only
// [RQ23] Zero flag from result; unlisted flags keep value
package rss_pkg;

  // ==================================================
  // Register map (byte addresses)
  localparam logic [11:0] RSS_OFF_INSTR = 12'h000;
  localparam logic [11:0] RSS_OFF_ACC = 12'h004;
  localparam logic [11:0] RSS_OFF_STATUS = 12'h008;
  localparam logic [11:0] RSS_OFF_TPTR = 12'h00c;
  localparam logic [11:0] RSS_OFF_THI = 12'h010;
  localparam logic [11:0] RSS_OFF_PAGE = 12'h014;
  localparam logic [11:0] RSS_OFF_MEM = 12'h040;
  localparam int RSS_MEM_AW = 4;

  // ==================================================
  // Field positions
  localparam int RSS_INSTR_OP_LSB = 0;
  localparam int RSS_INSTR_BIT_LSB = 5;
  localparam int RSS_INSTR_ADR_LSB = 8;
  localparam int RSS_INSTR_IMM_LSB = 16;
  localparam int RSS_ST_C = 0;
  localparam int RSS_ST_AUX = 1;
  localparam int RSS_ST_Z = 2;
  localparam int RSS_ST_OVF = 3;
  localparam int RSS_ST_BUSY = 8;
  localparam int RSS_ST_SKIP = 9;

  // ==================================================
  // Reset values and fixed constants
  localparam logic [7:0] RSS_ACC_RST = 8'h00;
  localparam logic [7:0] RSS_TPTR_RST = 8'h00;
  localparam logic [7:0] RSS_THI_RST = 8'h00;
  localparam logic [7:0] RSS_PAGE_RST = 8'h00;
  localparam logic [7:0] RSS_LAST_PAGE = 8'hff;
  localparam logic [7:0] RSS_ALL_ONES = 8'hff;

  // ==================================================
  // Operations
  typedef enum logic [4:0] {
    rotate_left_via_carry = 5'h00, rotate_left_via_carry_to_acc = 5'h01,
    rotate_right = 5'h02, rotate_right_to_acc = 5'h03,
    rotate_right_via_carry = 5'h04, rotate_right_via_carry_to_acc = 5'h05,
    subtract_with_borrow = 5'h06, subtract_with_borrow_to_memory = 5'h07,
    subtract_plain = 5'h08, minus_into_memory = 5'h09, subtract_immediate = 5'h0a,
    decrement_skip_zero = 5'h0b, decrement_skip_zero_to_acc = 5'h0c,
    increment_skip_zero = 5'h0d, increment_skip_zero_to_acc = 5'h0e,
    skip_bit_nonzero = 5'h0f, skip_bit_zero = 5'h10,
    skip_if_zero = 5'h11, skip_if_zero_move_acc = 5'h12,
    set_byte = 5'h13, set_bit = 5'h14,
    nibble_exchange = 5'h15, nibble_exchange_to_acc = 5'h16,
    table_read_current_page = 5'h17, table_read_last_page = 5'h18,
    exclusive_or = 5'h19, exclusive_or_into_memory = 5'h1a, exclusive_or_immediate = 5'h1b
  } rss_op_t;

  typedef struct packed {
    logic ovf;
    logic z;
    logic aux;
    logic c;
  } rss_flags_t;

  typedef struct packed {
    logic [7:0] res;
    logic wr_acc;
    logic wr_mem;
    logic skip;
    logic tbl;
    rss_flags_t fl;
  } rss_alu_out_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01,
    st_dummy = 2'b11,
    st_table = 2'b10
  } rss_state_t;

endpackage : rss_pkg

// file: core/rss_alu.sv
// Combinational datapath for one instruction of the set
`timescale 1ns/1ps
module rss_alu
  import rss_pkg::*;
(
  input wire rss_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [7:0] imm,
  input wire logic [2:0] bsel,
  input wire rss_flags_t fl_in,
  output rss_alu_out_t out
);

  // ==================================================
  // Subtract operands and flags
  wire logic sub_imm = (op == subtract_immediate);
  wire logic sub_brw = (op == subtract_with_borrow) || (op == subtract_with_borrow_to_memory);
  wire logic [7:0] sub_b = sub_imm ? imm : mem; // see [RQ11]
  wire logic borrow = sub_brw & ~fl_in.c; // see [RQ7]
  wire logic [8:0] diff = {1'b0, acc} - {1'b0, sub_b} - {8'h00, borrow};
  wire logic [4:0] ldiff = {1'b0, acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, borrow};
  wire logic sub_ovf = (acc[7] != sub_b[7]) && (diff[7] != acc[7]);
  wire rss_flags_t sub_fl = '{ovf: sub_ovf, z: (diff[7:0] == 8'h00), aux: ~ldiff[4], c: ~diff[8]}; // see [RQ8] see [RQ9]
  wire logic [7:0] dec = mem - 8'h01;
  wire logic [7:0] inc = mem + 8'h01;
  wire logic mbit = mem[bsel];
  wire logic [7:0] onehot = 8'h01 << bsel;
  wire logic [7:0] xres = acc ^ ((op == exclusive_or_immediate) ? imm : mem);

  // Per-operation result, destination and flags
  always_comb begin
    out = '{res: mem, wr_acc: 1'b0, wr_mem: 1'b0, skip: 1'b0, tbl: 1'b0, fl: fl_in}; // see [RQ23]
    unique case (op)
      rotate_left_via_carry, rotate_left_via_carry_to_acc: begin
        out.res = {mem[6:0], fl_in.c}; // see [RQ1]
        out.fl.c = mem[7]; // see [RQ2]
        out.wr_acc = (op == rotate_left_via_carry_to_acc);
        out.wr_mem = (op == rotate_left_via_carry);
      end
      rotate_right, rotate_right_to_acc: begin
        out.res = {mem[0], mem[7:1]}; // see [RQ3]
        out.wr_acc = (op == rotate_right_to_acc); // see [RQ4]
        out.wr_mem = (op == rotate_right);
      end
      rotate_right_via_carry, rotate_right_via_carry_to_acc: begin
        out.res = {fl_in.c, mem[7:1]}; // see [RQ5]
        out.fl.c = mem[0]; // see [RQ6]
        out.wr_acc = (op == rotate_right_via_carry_to_acc);
        out.wr_mem = (op == rotate_right_via_carry);
      end
      subtract_with_borrow, subtract_with_borrow_to_memory, subtract_plain, minus_into_memory,
      subtract_immediate: begin
        out.res = diff[7:0];
        out.fl = sub_fl; // see [RQ9]
        out.wr_mem = (op == subtract_with_borrow_to_memory) || (op == minus_into_memory); // see [RQ10]
        out.wr_acc = ~out.wr_mem; // see [RQ7]
      end
      decrement_skip_zero, decrement_skip_zero_to_acc: begin
        out.res = dec;
        out.skip = (dec == 8'h00); // see [RQ12]
        out.wr_acc = (op == decrement_skip_zero_to_acc); // see [RQ13]
        out.wr_mem = (op == decrement_skip_zero);
      end
      increment_skip_zero, increment_skip_zero_to_acc: begin
        out.res = inc;
        out.skip = (inc == 8'h00); // see [RQ14]
        out.wr_acc = (op == increment_skip_zero_to_acc);
        out.wr_mem = (op == increment_skip_zero);
      end
      skip_bit_nonzero: out.skip = mbit; // see [RQ15]
      skip_bit_zero: out.skip = ~mbit; // see [RQ16]
      skip_if_zero, skip_if_zero_move_acc: begin
        out.skip = (mem == 8'h00); // see [RQ17]
        out.wr_acc = (op == skip_if_zero_move_acc);
      end
      set_byte: begin
        out.res = RSS_ALL_ONES; // see [RQ19]
        out.wr_mem = 1'b1;
      end
      set_bit: begin
        out.res = mem | onehot; // see [RQ19]
        out.wr_mem = 1'b1;
      end
      nibble_exchange, nibble_exchange_to_acc: begin
        out.res = {mem[3:0], mem[7:4]}; // see [RQ20]
        out.wr_acc = (op == nibble_exchange_to_acc);
        out.wr_mem = (op == nibble_exchange);
      end
      table_read_current_page, table_read_last_page: out.tbl = 1'b1; // see [RQ21]
      exclusive_or, exclusive_or_into_memory, exclusive_or_immediate: begin
        out.res = xres;
        out.fl.z = (xres == 8'h00); // see [RQ22]
        out.wr_mem = (op == exclusive_or_into_memory);
        out.wr_acc = ~out.wr_mem;
      end
      default: out.res = mem;
    endcase
  end

endmodule : rss_alu

// file: tb/rss_core_properties.sv
// Port-level checks for the execution unit
`timescale 1ns/1ps
module rss_core_properties
  import rss_pkg::*;
#(
  parameter int MEM_AW = RSS_MEM_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] tbl_addr,
  input wire logic [15:0] tbl_word,
  input wire logic busy,
  input wire logic skip_pulse
);
  // ==================================================
  // Decoded bus events
  wire logic acc_cyc = psel && penable;
  wire logic wr_cyc = acc_cyc && pwrite;
  wire logic launch = wr_cyc && (paddr == RSS_OFF_INSTR) && !busy;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==================================================
  // Assertions
  a_launch_busy: assert property (launch |=> busy)
    else $error("busy did not follow an instruction write");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:2] !busy)
    else $error("instruction took more than two cycles");
  a_skip_single: assert property (skip_pulse |=> !skip_pulse && !busy)
    else $error("dummy cycle longer than one cycle");
  a_skip_in_op: assert property (skip_pulse |-> busy && $past(busy))
    else $error("dummy cycle without a preceding execute cycle");
  a_busy_refuse: assert property (wr_cyc && busy |-> pslverr)
    else $error("write while busy not refused");
  a_latch_ro: assert property (wr_cyc && paddr == RSS_OFF_THI |-> pslverr)
    else $error("write to table latch not refused");
  a_tbl_hold: assert property (!busy |=> $stable(tbl_addr))
    else $error("table address moved while idle");
  a_status_busy: assert property (acc_cyc && !pwrite && paddr == RSS_OFF_STATUS
    |-> prdata[RSS_ST_BUSY] == busy)
    else $error("status busy bit differs from busy");

  // ==================================================
  // Scenario covers
  c_skip: cover property (skip_pulse);
  c_refuse: cover property (wr_cyc && busy);
  c_long: cover property ($rose(busy) ##1 busy ##1 !busy);
endmodule : rss_core_properties

bind rss_core rss_core_properties #(.MEM_AW(MEM_AW)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tbl_addr(tbl_addr), .tbl_word(tbl_word), .busy(busy), .skip_pulse(skip_pulse)
);

// file: tb/mcu_rotate_subtract_skip_ops_test.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module mcu_rotate_subtract_skip_ops_test
  import rss_pkg::*;
;
  // ==================================================
  // Signals
  localparam logic [11:0] MADR = RSS_OFF_MEM + 12'h014;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] tbl_addr;
  wire logic [15:0] tbl_word;
  logic busy;
  logic skip_pulse;
  logic [31:0] rdat;
  logic rerr;
  logic [11:0] rz [4] = '{RSS_OFF_ACC, RSS_OFF_STATUS, RSS_OFF_TPTR, RSS_OFF_THI};
  int skips = 0;
  int err_total = 0;
  int total_checks = 0;

  always #5 pclk = ~pclk;
  // Program memory gives a scrambled copy of its address
  assign tbl_word = {tbl_addr[7:0], tbl_addr[15:8]} ^ 16'h3c5a;
  // Count dummy cycles
  always @(posedge pclk) begin
    if (skip_pulse === 1'b1)
      skips <= skips + 1;
  end

  rss_core #(.MEM_AW(RSS_MEM_AW)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tbl_addr(tbl_addr), .tbl_word(tbl_word), .busy(busy), .skip_pulse(skip_pulse)
  );

  // ==================================================
  // Tasks
  task automatic results;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // One transfer; hold keeps psel up for a back-to-back follower
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic hold);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      results();
    end
    rdat = prdata;
    rerr = pslverr;
    penable <= 1'b0;
    if (!hold) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : bus

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, RSS_OFF_STATUS, 32'h0, 1'b0);
      n++;
    end while (rdat[RSS_ST_BUSY] !== 1'b0 && n < 10);
    if (rdat[RSS_ST_BUSY] !== 1'b0) begin
      err_total++;
      results();
    end
  endtask : wait_idle

  function automatic logic [31:0] ins(input rss_op_t op, input logic [7:0] x);
    return {8'h00, x, 4'h0, 4'h5, x[2:0], op};
  endfunction : ins

  // Load operands, run one instruction, compare all results
  task automatic t(input rss_op_t op, input logic [7:0] x, input logic [7:0] m, input logic [7:0] a,
                   input logic [3:0] f, input logic [7:0] ea, input logic [7:0] em,
                   input logic [3:0] ef, input int es);
    int s0;
    bus(1'b1, MADR, {24'h0, m}, 1'b0);
    bus(1'b1, RSS_OFF_ACC, {24'h0, a}, 1'b0);
    bus(1'b1, RSS_OFF_STATUS, {28'h0, f}, 1'b0);
    s0 = skips;
    bus(1'b1, RSS_OFF_INSTR, ins(op, x), 1'b0);
    wait_idle();
    chk("skips", es, skips - s0);
    bus(1'b0, RSS_OFF_ACC, 32'h0, 1'b0);
    chk("acc", {24'h0, ea}, rdat);
    bus(1'b0, MADR, 32'h0, 1'b0);
    chk("mem", {24'h0, em}, rdat);
    bus(1'b0, RSS_OFF_STATUS, 32'h0, 1'b0);
    chk("flags", {28'h0, ef}, rdat & 32'h0000000f);
  endtask : t

  // ==================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rz[i]) begin
      bus(1'b0, rz[i], 32'h0, 1'b0);
      chk("reset", 32'h0, rdat);
    end
    t(rotate_left_via_carry, 8'h00, 8'h81, 8'h3c, 4'hc, 8'h3c, 8'h02, 4'hd, 0);
    t(rotate_left_via_carry_to_acc, 8'h00, 8'h40, 8'h00, 4'h1, 8'h81, 8'h40, 4'h0, 0);
    t(rotate_right, 8'h00, 8'h01, 8'h00, 4'hf, 8'h00, 8'h80, 4'hf, 0);
    t(rotate_right_to_acc, 8'h00, 8'h03, 8'h00, 4'h0, 8'h81, 8'h03, 4'h0, 0);
    t(rotate_right_via_carry, 8'h00, 8'h02, 8'h00, 4'h1, 8'h00, 8'h81, 4'h0, 0);
    t(rotate_right_via_carry_to_acc, 8'h00, 8'h01, 8'hff, 4'h0, 8'h00, 8'h01, 4'h1, 0);
    t(subtract_with_borrow, 8'h00, 8'h01, 8'h10, 4'h0, 8'h0e, 8'h01, 4'h1, 0);
    t(subtract_with_borrow_to_memory, 8'h00, 8'h01, 8'h80, 4'h1, 8'h80, 8'h7f, 4'h9, 0);
    t(subtract_plain, 8'h00, 8'h05, 8'h05, 4'h8, 8'h00, 8'h05, 4'h7, 0);
    t(minus_into_memory, 8'h00, 8'h02, 8'h01, 4'h7, 8'h01, 8'hff, 4'h0, 0);
    t(subtract_immediate, 8'h11, 8'h99, 8'h20, 4'h0, 8'h0f, 8'h99, 4'h1, 0);
    t(decrement_skip_zero, 8'h00, 8'h01, 8'h00, 4'ha, 8'h00, 8'h00, 4'ha, 1);
    t(decrement_skip_zero_to_acc, 8'h00, 8'h01, 8'h55, 4'h0, 8'h00, 8'h01, 4'h0, 1);
    t(increment_skip_zero, 8'h00, 8'hff, 8'h00, 4'h5, 8'h00, 8'h00, 4'h5, 1);
    t(increment_skip_zero_to_acc, 8'h00, 8'h7f, 8'h00, 4'h0, 8'h80, 8'h7f, 4'h0, 0);
    t(skip_bit_nonzero, 8'h07, 8'h80, 8'h00, 4'h0, 8'h00, 8'h80, 4'h0, 1);
    t(skip_bit_zero, 8'h03, 8'h08, 8'h00, 4'h0, 8'h00, 8'h08, 4'h0, 0);
    t(skip_if_zero, 8'h00, 8'h00, 8'h66, 4'h0, 8'h66, 8'h00, 4'h0, 1);
    t(skip_if_zero_move_acc, 8'h00, 8'h42, 8'h00, 4'h0, 8'h42, 8'h42, 4'h0, 0);
    t(set_byte, 8'h00, 8'h00, 8'h00, 4'h5, 8'h00, 8'hff, 4'h5, 0);
    t(set_bit, 8'h02, 8'h00, 8'h00, 4'h0, 8'h00, 8'h04, 4'h0, 0);
    t(nibble_exchange, 8'h00, 8'h3c, 8'h00, 4'h0, 8'h00, 8'hc3, 4'h0, 0);
    t(nibble_exchange_to_acc, 8'h00, 8'h12, 8'h00, 4'h0, 8'h21, 8'h12, 4'h0, 0);
    t(exclusive_or, 8'h00, 8'h0f, 8'h0f, 4'hb, 8'h00, 8'h0f, 4'hf, 0);
    t(exclusive_or_into_memory, 8'h00, 8'h0f, 8'hf0, 4'h4, 8'hf0, 8'hff, 4'h0, 0);
    t(exclusive_or_immediate, 8'h55, 8'h00, 8'h55, 4'h0, 8'h00, 8'h00, 4'h4, 0);
    // Table reads in the current and the last page
    bus(1'b1, RSS_OFF_PAGE, 32'h12, 1'b0);
    bus(1'b1, RSS_OFF_TPTR, 32'h34, 1'b0);
    t(table_read_current_page, 8'h00, 8'h00, 8'h3c, 4'h0, 8'h3c, 8'h48, 4'h0, 0);
    bus(1'b0, RSS_OFF_THI, 32'h0, 1'b0);
    chk("latch", 32'h08, rdat);
    bus(1'b1, RSS_OFF_TPTR, 32'h77, 1'b0);
    t(table_read_last_page, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'ha5, 4'h0, 0);
    chk("taddr", 32'hff77, {16'h0, tbl_addr});
    bus(1'b1, RSS_OFF_THI, 32'h99, 1'b0);
    chk("latch err", 32'h1, {31'h0, rerr});
    bus(1'b0, RSS_OFF_THI, 32'h0, 1'b0);
    chk("latch", 32'h4b, rdat);
    // Write landing in the dummy cycle is refused
    bus(1'b1, RSS_OFF_ACC, 32'h11, 1'b0);
    bus(1'b1, MADR, 32'h0, 1'b0);
    bus(1'b1, RSS_OFF_INSTR, ins(skip_if_zero, 8'h00), 1'b1);
    bus(1'b1, RSS_OFF_ACC, 32'h77, 1'b0);
    chk("busy err", 32'h1, {31'h0, rerr});
    wait_idle();
    bus(1'b0, RSS_OFF_ACC, 32'h0, 1'b0);
    chk("acc kept", 32'h11, rdat);
    // Clear the sticky skip bit, then read status in a dummy cycle
    bus(1'b1, RSS_OFF_STATUS, 32'h1 << RSS_ST_SKIP, 1'b0);
    bus(1'b0, RSS_OFF_STATUS, 32'h0, 1'b0);
    chk("skip clr", 32'h0, {31'h0, rdat[RSS_ST_SKIP]});
    bus(1'b1, RSS_OFF_INSTR, ins(skip_if_zero, 8'h00), 1'b1);
    bus(1'b0, RSS_OFF_STATUS, 32'h0, 1'b0);
    chk("busy bit", 32'h1, {31'h0, rdat[RSS_ST_BUSY]});
    wait_idle();
    chk("skip seen", 32'h1, {31'h0, rdat[RSS_ST_SKIP]});
    bus(1'b0, 12'h100, 32'h0, 1'b0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    results();
  end
endmodule : mcu_rotate_subtract_skip_ops_test
